// ==== cpx_bus_if.sv ====
// Purpose: request/answer carrier between sequencer and register access port
// Assumes: both ends on clk
// Notes: req held until done; done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface cpx_bus_if;
  logic req;
  logic wr;
  cpx_pkg::cpx_reg_t sel;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic done;
  modport mst (output req, output wr, output sel, output wdata, input rdata, input done);
  modport prt (input req, input wr, input sel, input wdata, output rdata, output done);
endinterface
`default_nettype wire

// ==== cpx_cir_port.sv ====
// Purpose: runs one interface register access on the coprocessor pins
// Assumes: ack pair and data arrive asynchronously, two-flop synchronised
// Notes: no timeout; an access without acknowledge waits forever
`timescale 1ns/1ps
`default_nettype none
module cpx_cir_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  cpx_bus_if.prt bus,
  output logic cir_strobe,
  output logic cir_rd_wr_n,
  output logic [3:0] cir_sel,
  output logic [31:0] cir_dout,
  output logic cir_doe,
  input wire logic [31:0] cir_din,
  input wire logic [1:0] data_size_ack_pair_n
);
  // =========================================================
  // synchronisers
  logic [1:0] ack_s1_r, ack_s2_r;
  logic [31:0] din_s1_r, din_s2_r;
  logic busy_r;
  logic ack_seen;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_s1_r <= 2'h3;
      ack_s2_r <= 2'h3;
      din_s1_r <= 32'h0000_0000;
      din_s2_r <= 32'h0000_0000;
    end else if (ce) begin
      ack_s1_r <= data_size_ack_pair_n;
      ack_s2_r <= ack_s1_r;
      din_s1_r <= cir_din;
      din_s2_r <= din_s1_r;
    end
  end

  assign ack_seen = busy_r && (ack_s2_r != 2'h3);

  // =========================================================
  // one access at a time; waits with no limit for the acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      cir_strobe <= 1'b0;
      cir_rd_wr_n <= 1'b1;
      cir_sel <= 4'h0;
      cir_dout <= 32'h0000_0000;
      cir_doe <= 1'b0;
      bus.rdata <= 32'h0000_0000;
      bus.done <= 1'b0;
    end else if (ce) begin
      bus.done <= 1'b0;
      if (!busy_r && bus.req && !bus.done) begin
        busy_r <= 1'b1;
        cir_strobe <= 1'b1;
        cir_rd_wr_n <= !bus.wr;
        cir_sel <= bus.sel;
        cir_dout <= bus.wdata;
        cir_doe <= bus.wr;
      end else if (ack_seen) begin // no timeout here
        busy_r <= 1'b0;
        cir_strobe <= 1'b0;
        cir_doe <= 1'b0;
        bus.rdata <= din_s2_r;
        bus.done <= 1'b1;
      end
    end
  end

  // a strobe drops only on an acknowledge
  strobe_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && cir_strobe && (ack_s2_r == 2'h3) |=> cir_strobe)
    else $error("strobe dropped without acknowledge");
endmodule
`default_nettype wire

// ==== cpx_cop_model.sv ====
// Purpose: coprocessor side of the interface register pins
// Assumes: acknowledge driven low as a pair, held until strobe drops
// Notes: hold never acknowledges; slow adds wait cycles
`timescale 1ns/1ps
`default_nettype none
module cpx_cop_model #(
  parameter logic [31:0] RESP_WORD = 32'h5A00_1C00,
  // primitive code bits above the vector field; value arbitrary
  parameter logic [23:0] MID_CODE = 24'h00_0001
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hold,
  input wire logic slow,
  input wire logic expect_cmd,
  input wire logic ctx_busy,
  input wire logic cir_strobe,
  input wire logic cir_rd_wr_n,
  input wire logic [3:0] cir_sel,
  input wire logic [31:0] cir_dout,
  output logic [31:0] cir_din,
  output logic [1:0] data_size_ack_pair_n,
  output logic [7:0] n_ctrl,
  output logic [7:0] n_resp,
  output logic [31:0] last_ctrl,
  output logic [7:0] n_viol
);
  logic [3:0] wait_r;
  logic viol_r;
  logic resp_rd;
  logic seq_hit;
  // a response read is where a held violation is handed over
  assign resp_rd = cir_rd_wr_n && cir_sel == 4'(cpx_pkg::CPX_REG_RESPONSE);
  // one of the five sequenced registers while command or condition is awaited
  assign seq_hit = expect_cmd && (cir_sel == 4'(cpx_pkg::CPX_REG_OPWORD) ||
                   cir_sel > 4'(cpx_pkg::CPX_REG_CONDITION));
  // ====================================================
  // access responder
  // every access is acknowledged once hold is low, any register, any time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_size_ack_pair_n <= 2'b11;
      cir_din <= 32'h0000_0000;
      wait_r <= 4'h0;
      n_ctrl <= 8'h00;
      n_resp <= 8'h00;
      n_viol <= 8'h00;
      viol_r <= 1'b0;
      last_ctrl <= 32'h0000_0000;
    end else if (cir_strobe && data_size_ack_pair_n == 2'b11) begin
      if (!hold && wait_r >= (slow ? 4'h7 : 4'h0)) begin
        data_size_ack_pair_n <= 2'b00;
        wait_r <= 4'h0;
        // held back while save or restore runs, sent at a later start
        if (resp_rd && viol_r && !ctx_busy) begin
          cir_din <= {MID_CODE, cpx_pkg::CPX_VEC_PROTOCOL}; // mid primitive
          viol_r <= 1'b0;
        end else begin
          cir_din <= RESP_WORD ^ {28'h0000000, cir_sel};
        end
        // the bad access is still acknowledged, reported later
        if (seq_hit) begin
          viol_r <= 1'b1;
          n_viol <= n_viol + 8'h01;
        end
        if (!cir_rd_wr_n && cir_sel == 4'(cpx_pkg::CPX_REG_CONTROL)) begin
          n_ctrl <= n_ctrl + 8'h01;
          last_ctrl <= cir_dout;
        end
        if (resp_rd) begin
          n_resp <= n_resp + 8'h01;
        end
      end else begin
        wait_r <= wait_r + 4'h1; // slow or stalled acknowledge
      end
    end else if (!cir_strobe) begin
      // released bus shows a changing pattern, not the last value
      data_size_ack_pair_n <= 2'b11;
      cir_din <= ~cir_din;
    end
  end
endmodule
`default_nettype wire

// ==== cpx_pkg.sv ====
// Purpose: shared constants and types for the coprocessor exception sequencer
// Assumes: one 200 MHz clock, asynchronous active-low reset
// Notes: interface registers are named by select codes, not by bus addresses
`default_nettype none
package cpx_pkg;
  // =========================================================
  // interface register selects
  typedef enum logic [3:0] {
    CPX_REG_RESPONSE, CPX_REG_CONTROL, CPX_REG_SAVE, CPX_REG_RESTORE,
    CPX_REG_OPWORD, CPX_REG_COMMAND, CPX_REG_CONDITION, CPX_REG_OPERAND,
    CPX_REG_REGSEL, CPX_REG_INSTADDR, CPX_REG_OPERADDR
  } cpx_reg_t;
  // =========================================================
  // primitive kinds handed in by the dialog logic
  typedef enum logic [2:0] {
    CPX_PRIM_POST, CPX_PRIM_MID, CPX_PRIM_PRE, CPX_PRIM_FMTERR, CPX_PRIM_OTHER
  } cpx_prim_t;
  // instruction category currently in dialog
  typedef enum logic [2:0] {
    CPX_CAT_NONE, CPX_CAT_GEN, CPX_CAT_COND, CPX_CAT_SAVE, CPX_CAT_RESTORE
  } cpx_cat_t;
  // =========================================================
  // frame sizes in words and fixed vectors
  localparam logic [3:0] CPX_POST_WORDS = 4'h6;
  localparam logic [3:0] CPX_MID_WORDS = 4'hA;
  localparam logic [3:0] CPX_PRE_WORDS = 4'h4;
  localparam logic [7:0] CPX_VEC_PROTOCOL = 8'h0D;
  localparam logic [7:0] CPX_VEC_FORMAT = 8'h0E;
  // control register masks (plain defaults)
  localparam logic [15:0] CPX_ACK_MASK = 16'h0002;
  localparam logic [15:0] CPX_ABORT_MASK = 16'h0001;
  // reset values and synchroniser stage count
  localparam logic [31:0] CPX_ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] CPX_VEC_RST = 8'h00;
  localparam int CPX_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ==== cpx_seq.sv ====
// Purpose: main-processor exception sequencer for the coprocessor interface
// Assumes: dialog logic supplies primitives, categories and sequenced accesses
// Notes: owns the control-register acknowledge, frame requests and resume point
`timescale 1ns/1ps
`default_nettype none
module cpx_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic prim_valid,
  input wire cpx_pkg::cpx_prim_t prim_kind,
  input wire logic [7:0] prim_vector,
  input wire cpx_pkg::cpx_cat_t cur_cat,
  input wire logic [31:0] scan_ptr,
  input wire logic [31:0] opword_addr,
  input wire logic dialog_open,
  input wire logic seq_req,
  input wire cpx_pkg::cpx_reg_t seq_sel,
  input wire logic seq_wr,
  input wire logic [31:0] seq_wdata,
  output logic seq_done,
  output logic seq_refused,
  output logic [31:0] seq_rdata,
  output logic instr_done,
  output logic exc_req,
  input wire logic exc_ack,
  output logic [7:0] exc_vector,
  output logic [3:0] exc_words,
  output logic [31:0] exc_pc,
  output logic [31:0] exc_scan,
  input wire logic rte_req,
  input wire logic [3:0] rte_words,
  input wire logic [7:0] rte_vector,
  input wire logic rte_modified,
  input wire logic [31:0] rte_scan,
  output logic resume_valid,
  output logic [31:0] resume_addr,
  output logic resp_valid,
  output logic [31:0] resp_data,
  output logic cir_strobe,
  output logic cir_rd_wr_n,
  output logic [3:0] cir_sel,
  output logic [31:0] cir_dout,
  output logic cir_doe,
  input wire logic [31:0] cir_din,
  input wire logic [1:0] data_size_ack_pair_n
);
  // =========================================================
  // declarations
  typedef enum {CPX_IDLE, CPX_CTRL_WR, CPX_FRAME, CPX_RESP_RD, CPX_SEQ_ACC} cpx_state_t;
  cpx_state_t state_r;
  cpx_bus_if bus ();
  logic [15:0] mask_r;
  logic need_ctrl;
  logic accept_prim;
  logic post_ok;
  logic seq_legal;

  cpx_cir_port u_port (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .bus(bus.prt),
    .cir_strobe(cir_strobe),
    .cir_rd_wr_n(cir_rd_wr_n),
    .cir_sel(cir_sel),
    .cir_dout(cir_dout),
    .cir_doe(cir_doe),
    .cir_din(cir_din),
    .data_size_ack_pair_n(data_size_ack_pair_n)
  );

  // =========================================================
  // decode of incoming primitives
  assign accept_prim = prim_valid && (state_r == CPX_IDLE);
  assign post_ok = (cur_cat == cpx_pkg::CPX_CAT_GEN) ||
                   (cur_cat == cpx_pkg::CPX_CAT_COND);
  // a post primitive outside its categories is a processor-found violation: no ack
  assign need_ctrl = (prim_kind != cpx_pkg::CPX_PRIM_OTHER) &&
                     !((prim_kind == cpx_pkg::CPX_PRIM_POST) && !post_ok);
  // sequenced registers only while a dialog is open; the others any time
  assign seq_legal = dialog_open ||
                     (seq_sel == cpx_pkg::CPX_REG_RESPONSE) ||
                     (seq_sel == cpx_pkg::CPX_REG_CONTROL) ||
                     (seq_sel == cpx_pkg::CPX_REG_SAVE) ||
                     (seq_sel == cpx_pkg::CPX_REG_RESTORE) ||
                     (seq_sel == cpx_pkg::CPX_REG_COMMAND) ||
                     (seq_sel == cpx_pkg::CPX_REG_CONDITION);

  // =========================================================
  // bus requests follow the state; control write precedes the frame when need_ctrl is set
  always_comb begin
    bus.req = 1'b0;
    bus.wr = 1'b0;
    bus.sel = cpx_pkg::CPX_REG_RESPONSE;
    bus.wdata = 32'h0000_0000;
    case (state_r)
      CPX_CTRL_WR: begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.sel = cpx_pkg::CPX_REG_CONTROL;
        bus.wdata = {16'h0000, mask_r};
      end
      CPX_RESP_RD: begin
        bus.req = 1'b1;
      end
      CPX_SEQ_ACC: begin
        bus.req = 1'b1;
        bus.wr = seq_wr;
        bus.sel = seq_sel;
        bus.wdata = seq_wdata;
      end
      default: begin
        bus.req = 1'b0;
      end
    endcase
  end

  // =========================================================
  // main sequence; every coprocessor exception funnels through here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CPX_IDLE;
      mask_r <= 16'h0000;
    end else if (ce) begin
      case (state_r)
        CPX_IDLE: begin
          if (prim_valid) begin
            mask_r <= (prim_kind == cpx_pkg::CPX_PRIM_FMTERR) ?
                      cpx_pkg::CPX_ABORT_MASK : cpx_pkg::CPX_ACK_MASK;
            state_r <= need_ctrl ? CPX_CTRL_WR : CPX_FRAME;
          end else if (rte_req && !rte_modified && rte_words == cpx_pkg::CPX_MID_WORDS) begin
            state_r <= CPX_RESP_RD;
          end else if (seq_req && seq_legal && !rte_req) begin
            state_r <= CPX_SEQ_ACC;
          end
        end
        CPX_CTRL_WR: if (bus.done) state_r <= CPX_FRAME;
        CPX_FRAME: if (exc_ack) state_r <= CPX_IDLE;
        CPX_RESP_RD: if (bus.done) state_r <= CPX_IDLE;
        CPX_SEQ_ACC: if (bus.done) state_r <= CPX_IDLE;
        default: state_r <= CPX_IDLE;
      endcase
    end
  end

  // =========================================================
  // frame contents captured the cycle the primitive is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exc_vector <= cpx_pkg::CPX_VEC_RST;
      exc_words <= 4'h0;
      exc_pc <= cpx_pkg::CPX_ADDR_RST;
      exc_scan <= cpx_pkg::CPX_ADDR_RST;
    end else if (ce && accept_prim) begin
      exc_pc <= opword_addr;
      exc_scan <= scan_ptr;
      case (prim_kind)
        cpx_pkg::CPX_PRIM_POST: begin
          exc_vector <= post_ok ? prim_vector : cpx_pkg::CPX_VEC_PROTOCOL;
          exc_words <= post_ok ? cpx_pkg::CPX_POST_WORDS : cpx_pkg::CPX_MID_WORDS;
        end
        cpx_pkg::CPX_PRIM_MID: begin
          exc_vector <= prim_vector;
          exc_words <= cpx_pkg::CPX_MID_WORDS;
        end
        cpx_pkg::CPX_PRIM_FMTERR: begin // invalid format word path
          exc_vector <= cpx_pkg::CPX_VEC_FORMAT;
          exc_words <= cpx_pkg::CPX_PRE_WORDS;
        end
        cpx_pkg::CPX_PRIM_PRE: begin
          exc_vector <= prim_vector;
          exc_words <= cpx_pkg::CPX_PRE_WORDS;
        end
        default: begin // unknown primitive: processor-found violation
          exc_vector <= cpx_pkg::CPX_VEC_PROTOCOL;
          exc_words <= cpx_pkg::CPX_MID_WORDS;
        end
      endcase
    end
  end

  // =========================================================
  // pulses and held outputs towards the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exc_req <= 1'b0;
      instr_done <= 1'b0;
      resume_valid <= 1'b0;
      resume_addr <= cpx_pkg::CPX_ADDR_RST;
      resp_valid <= 1'b0;
      resp_data <= 32'h0000_0000;
      seq_done <= 1'b0;
      seq_refused <= 1'b0;
      seq_rdata <= 32'h0000_0000;
    end else if (ce) begin
      instr_done <= accept_prim && prim_kind == cpx_pkg::CPX_PRIM_POST && post_ok;
      exc_req <= (state_r == CPX_FRAME) ? !exc_ack :
                 (state_r == CPX_CTRL_WR && bus.done) ||
                 (accept_prim && !need_ctrl);
      resume_valid <= (state_r == CPX_IDLE) && !prim_valid && rte_req &&
                      rte_words == cpx_pkg::CPX_POST_WORDS;
      if ((state_r == CPX_IDLE) && rte_req && rte_words == cpx_pkg::CPX_POST_WORDS) begin
        resume_addr <= rte_scan;
      end
      resp_valid <= (state_r == CPX_RESP_RD) && bus.done;
      if ((state_r == CPX_RESP_RD) && bus.done) begin
        resp_data <= bus.rdata;
      end
      seq_done <= (state_r == CPX_SEQ_ACC) && bus.done;
      if ((state_r == CPX_SEQ_ACC) && bus.done) begin
        seq_rdata <= bus.rdata;
      end
      seq_refused <= (state_r == CPX_IDLE) && !prim_valid && !rte_req &&
                     seq_req && !seq_legal;
    end
  end

  // =========================================================
  // checks
  ack_first_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim && need_ctrl |=> state_r == CPX_CTRL_WR && !exc_req)
    else $error("frame started before acknowledge write");
  ack_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    state_r == CPX_CTRL_WR |-> bus.sel == cpx_pkg::CPX_REG_CONTROL && bus.wr)
    else $error("acknowledge not aimed at control register");
  post_frame_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim && prim_kind == cpx_pkg::CPX_PRIM_POST && post_ok
    |=> exc_words == 4'h6 && exc_vector == $past(prim_vector))
    else $error("post frame size or vector wrong");
  scan_save_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim |=> exc_scan == $past(scan_ptr))
    else $error("scan pointer not saved");
  pc_save_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim |=> exc_pc == $past(opword_addr))
    else $error("operation word address not saved");
  post_cat_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim && prim_kind == cpx_pkg::CPX_PRIM_POST && !post_ok
    |=> exc_vector == 8'h0D && !instr_done)
    else $error("post primitive taken outside its categories");
  done_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && instr_done |=> !instr_done)
    else $error("instruction end not a single pulse");
  resume_scan_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == CPX_IDLE && !prim_valid && rte_req && rte_words == 4'h6
    |=> resume_valid && resume_addr == $past(rte_scan))
    else $error("post return not at saved scan pointer");
  resp_read_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == CPX_IDLE && !prim_valid && rte_req && !rte_modified && rte_words == 4'hA
    |=> bus.req && !bus.wr && bus.sel == cpx_pkg::CPX_REG_RESPONSE)
    else $error("violation return did not read response");
  seq_guard_a: assert property (@(posedge clk) disable iff (!rstn)
    state_r == CPX_SEQ_ACC && !dialog_open |-> seq_legal)
    else $error("sequenced register reached outside dialog");
  all_exc_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && accept_prim |-> ##[1:2] (state_r == CPX_CTRL_WR || exc_req))
    else $error("exception not processed");
endmodule
`default_nettype wire

// ==== cpx_seq_tb.sv ====
// Purpose: self-checking bench for the exception sequencer
// Assumes: inputs driven at the falling edge, fixed seed
// Notes: expectations come from the bench functions below
`timescale 1ns/1ps
`default_nettype none
module cpx_seq_tb;
  localparam logic [31:0] RW = 32'h5A00_1C00;
  logic clk = 1'b0, rstn = 1'b0, prim_valid = 1'b0, dialog_open = 1'b0, seq_req = 1'b0;
  logic seq_wr = 1'b0, exc_ack = 1'b0, rte_req = 1'b0, rte_modified = 1'b0, hold = 1'b0;
  logic slow = 1'b0, seq_done, seq_refused, instr_done, exc_req, resume_valid, resp_valid;
  logic cir_strobe, cir_rd_wr_n, cir_doe;
  cpx_pkg::cpx_prim_t prim_kind = cpx_pkg::CPX_PRIM_POST;
  cpx_pkg::cpx_cat_t cur_cat = cpx_pkg::CPX_CAT_NONE;
  cpx_pkg::cpx_reg_t seq_sel = cpx_pkg::CPX_REG_RESPONSE;
  logic [7:0] prim_vector = 8'h00, rte_vector = 8'h00, exc_vector, n_ctrl, n_resp;
  logic [3:0] rte_words = 4'h0, exc_words, cir_sel;
  logic [31:0] scan_ptr = 32'h0, opword_addr = 32'h0, seq_wdata = 32'h0, rte_scan = 32'h0;
  logic [31:0] seq_rdata, exc_pc, exc_scan, resume_addr, resp_data, cir_dout, cir_din;
  logic [31:0] last_ctrl;
  logic [7:0] n_viol;
  logic [1:0] ack_n;
  int n_fail = 0, num_checks = 0, seed = 32'h3643d18a;
  always #2.5 clk = ~clk;
  // ====================================================
  // design and coprocessor
  cpx_seq u_cpx_seq (.clk(clk), .rstn(rstn), .ce(1'b1), .prim_valid(prim_valid),
    .prim_kind(prim_kind), .prim_vector(prim_vector), .cur_cat(cur_cat), .scan_ptr(scan_ptr),
    .opword_addr(opword_addr), .dialog_open(dialog_open), .seq_req(seq_req), .seq_sel(seq_sel),
    .seq_wr(seq_wr), .seq_wdata(seq_wdata), .seq_done(seq_done), .seq_refused(seq_refused),
    .seq_rdata(seq_rdata), .instr_done(instr_done), .exc_req(exc_req), .exc_ack(exc_ack),
    .exc_vector(exc_vector), .exc_words(exc_words), .exc_pc(exc_pc), .exc_scan(exc_scan),
    .rte_req(rte_req), .rte_words(rte_words), .rte_vector(rte_vector),
    .rte_modified(rte_modified), .rte_scan(rte_scan), .resume_valid(resume_valid),
    .resume_addr(resume_addr), .resp_valid(resp_valid), .resp_data(resp_data),
    .cir_strobe(cir_strobe), .cir_rd_wr_n(cir_rd_wr_n), .cir_sel(cir_sel),
    .cir_dout(cir_dout), .cir_doe(cir_doe), .cir_din(cir_din), .data_size_ack_pair_n(ack_n));
  cpx_cop_model #(.RESP_WORD(RW)) u_cpx_cop_model (.clk(clk), .rstn(rstn), .hold(hold),
    .slow(slow), .cir_strobe(cir_strobe), .cir_rd_wr_n(cir_rd_wr_n), .cir_sel(cir_sel),
    .cir_dout(cir_dout), .cir_din(cir_din), .data_size_ack_pair_n(ack_n), .n_ctrl(n_ctrl),
    .n_resp(n_resp), .last_ctrl(last_ctrl), .expect_cmd(!dialog_open),
    .ctx_busy(cur_cat == cpx_pkg::CPX_CAT_SAVE || cur_cat == cpx_pkg::CPX_CAT_RESTORE),
    .n_viol(n_viol));
  // ====================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // acknowledge write needed unless processor itself found the fault
  function automatic bit e_need(cpx_pkg::cpx_prim_t k, cpx_pkg::cpx_cat_t c);
    if (k == cpx_pkg::CPX_PRIM_POST) begin
      return c == cpx_pkg::CPX_CAT_GEN || c == cpx_pkg::CPX_CAT_COND;
    end
    return k != cpx_pkg::CPX_PRIM_OTHER;
  endfunction
  function automatic logic [3:0] e_words(cpx_pkg::cpx_prim_t k, bit need);
    if (!need || k == cpx_pkg::CPX_PRIM_MID) return cpx_pkg::CPX_MID_WORDS;
    return k == cpx_pkg::CPX_PRIM_POST ? cpx_pkg::CPX_POST_WORDS : cpx_pkg::CPX_PRE_WORDS;
  endfunction
  function automatic logic [7:0] e_vec(cpx_pkg::cpx_prim_t k, bit need, logic [7:0] v);
    if (!need) return cpx_pkg::CPX_VEC_PROTOCOL;
    return k == cpx_pkg::CPX_PRIM_FMTERR ? cpx_pkg::CPX_VEC_FORMAT : v;
  endfunction
  // ====================================================
  // one primitive through to exception acknowledge
  task automatic prim(input cpx_pkg::cpx_prim_t k, input cpx_pkg::cpx_cat_t c);
    logic [7:0] v, c0;
    logic [31:0] sp, op;
    bit need, done_seen;
    int i;
    v = 8'($random(seed));
    sp = $random(seed);
    op = $random(seed);
    need = e_need(k, c);
    c0 = n_ctrl;
    slow = 1'($random(seed));
    prim_valid = 1'b1;
    prim_kind = k;
    prim_vector = v;
    cur_cat = c;
    scan_ptr = sp;
    opword_addr = op;
    @(negedge clk);
    prim_valid = 1'b0;
    scan_ptr = ~sp;
    opword_addr = ~op;
    done_seen = instr_done === 1'b1;
    for (i = 0; i < 60 && exc_req !== 1'b1; i++) begin
      @(negedge clk);
      done_seen |= instr_done === 1'b1;
    end
    chk("exc_req", exc_req, 1);
    chk("ack writes", n_ctrl - c0, need);
    if (need) chk("ack mask", last_ctrl, k == cpx_pkg::CPX_PRIM_FMTERR ? 
      cpx_pkg::CPX_ABORT_MASK : cpx_pkg::CPX_ACK_MASK);
    chk("exc_vector", exc_vector, e_vec(k, need, v));
    chk("exc_words", exc_words, e_words(k, need));
    chk("instr_done", done_seen, k == cpx_pkg::CPX_PRIM_POST && need);
    if (k == cpx_pkg::CPX_PRIM_POST && need) begin
      chk("exc_scan", exc_scan, sp);
      chk("exc_pc", exc_pc, op);
    end
    exc_ack = 1'b1;
    @(negedge clk);
    exc_ack = 1'b0;
    repeat (2) @(negedge clk);
    chk("exc_req low", exc_req, 0);
  endtask
  // handler return with a given frame size
  task automatic rte(input logic [3:0] w, input logic m);
    logic [31:0] sc;
    logic [7:0] r0;
    bit rv, pv;
    int i;
    sc = $random(seed);
    r0 = n_resp;
    rv = 0;
    pv = 0;
    rte_req = 1'b1;
    rte_words = w;
    rte_modified = m;
    rte_scan = sc;
    rte_vector = 8'($random(seed));
    @(negedge clk);
    rte_req = 1'b0;
    if (resume_valid === 1'b1) chk("resume_addr", resume_addr, sc);
    rv = resume_valid === 1'b1;
    for (i = 0; i < 40; i++) begin
      if (resp_valid === 1'b1) begin
        pv = 1;
        chk("resp_data", resp_data, RW);
      end
      @(negedge clk);
    end
    chk("resume_valid", rv, w == cpx_pkg::CPX_POST_WORDS);
    chk("resp_valid", pv, w == cpx_pkg::CPX_MID_WORDS && !m);
    chk("resp reads", n_resp - r0, w == cpx_pkg::CPX_MID_WORDS && !m);
  endtask
  // one sequenced or free register access; stall holds the acknowledge back
  task automatic acc(input int s, input bit refuse, input bit stall);
    int i;
    seq_req = 1'b1;
    seq_sel = cpx_pkg::cpx_reg_t'(s);
    seq_wr = 1'($random(seed));
    seq_wdata = $random(seed);
    hold = stall;
    if (stall) begin
      repeat (40) @(negedge clk);
      chk("stall done", seq_done, 0);
      chk("stall strobe", cir_strobe, 1);
      hold = 1'b0;
    end
    for (i = 0; i < 40 && seq_done !== 1'b1 && seq_refused !== 1'b1; i++) @(negedge clk);
    chk("seq_refused", seq_refused, refuse);
    chk("seq_done", seq_done, !refuse);
    if (!refuse && !seq_wr) chk("seq_rdata", seq_rdata, RW ^ s);
    seq_req = 1'b0;
    @(negedge clk);
  endtask
  // ====================================================
  // main sequence and watchdog
  initial begin
    int s;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk("rst exc_req", exc_req, 0);
    chk("rst strobe", cir_strobe, 0);
    chk("rst rd_wr_n", cir_rd_wr_n, 1);
    dialog_open = 1'b1; // post arrives while release or condition awaited
    for (s = 0; s < 5; s++) prim(cpx_pkg::CPX_PRIM_POST, cpx_pkg::cpx_cat_t'(s));
    // kind 3 stands for an invalid format word seen on save or restore
    for (s = 1; s < 5; s++) prim(cpx_pkg::cpx_prim_t'(s), cpx_pkg::CPX_CAT_GEN);
    repeat (16) prim(cpx_pkg::cpx_prim_t'($unsigned($random(seed)) % 5),
      cpx_pkg::cpx_cat_t'($unsigned($random(seed)) % 5));
    rte(4'h6, 1'b0);
    rte(4'h6, 1'b1);
    rte(4'hA, 1'b0);
    rte(4'hA, 1'b1);
    rte(4'h4, 1'b0);
    for (s = 0; s < 11; s++) acc(s, 0, s == 4);
    dialog_open = 1'b0;
    for (s = 0; s < 11; s++) acc(s, s == 4 || s > 6, 0);
    chk("cop violations", n_viol, 8'h00);
    end_sim();
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
